// ===== verilog/sfrxc_pkg.sv
/*
  Package for the serial FIFO receive-configuration block: register offsets,
  field positions, reset values, duplex codes and FIFO depths.
  Assumes a 32-bit APB register port with word-aligned registers.
*/
package sfrxc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_GENERAL = 8'h00;
  localparam logic [7:0] OFS_RXCFG   = 8'h04;
  localparam logic [7:0] OFS_RXSTAT  = 8'h08;
  localparam logic [7:0] OFS_CHANNEL = 8'h0C;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int GEN_FIFO_EN   = 0;
  localparam int GEN_AUTO_STOP = 1;
  localparam int GEN_USAGE     = 4;
  localparam int RXC_LEVEL_LO  = 0;
  localparam int RXC_COND      = 6;
  localparam int RXC_CLEAR     = 7;
  localparam int CH_DUPLEX_LO  = 0;
  localparam int CH_RX_EN      = 2;
  localparam int CH_TX_EN      = 3;
  localparam int CH_NINE_BIT   = 4;

  localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Duplex codes and depths
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SFRXC_DPX_NONE,
    SFRXC_DPX_HALF_TX,
    SFRXC_DPX_HALF_RX,
    SFRXC_DPX_FULL
  } sfrxc_duplex_t;

  localparam logic [2:0] DEPTH_HALF = 3'h4;
  localparam logic [2:0] DEPTH_FULL = 3'h2;
  localparam logic [2:0] LVL_ONE    = 3'h1;
  localparam logic [2:0] LVL_TWO    = 3'h2;
  localparam logic [2:0] LVL_THREE  = 3'h3;

endpackage : sfrxc_pkg

// ===== verilog/sfrxc_rx_fifo.sv
/*
  Receive FIFO storage with a fill level and a synchronous clear.
  Assumes the writer honours full and the reader honours empty.
*/
`timescale 1ns/1ps
`default_nettype none

module sfrxc_rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Control
  input  wire logic             clear,
  input  wire logic [2:0]       limit,
  // Write side
  input  wire logic             wr_valid,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  wr_ready,
  // Read side
  input  wire logic             rd_ready,
  output logic                  rd_valid,
  output logic      [WIDTH-1:0] rd_data,
  output logic      [2:0]       level
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [1:0]       wptr;
  logic [1:0]       rptr;
  wire              do_wr = wr_valid && wr_ready;
  wire              do_rd = rd_valid && rd_ready;

  // Depth limit follows the duplex split
  assign wr_ready = (level < limit) && !clear;
  assign rd_valid = (level != 3'h0);
  assign rd_data  = mem[rptr];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr  <= 2'h0;
      rptr  <= 2'h0;
      level <= 3'h0;
    end else if (ce) begin
      if (clear) begin
        wptr  <= 2'h0;
        rptr  <= 2'h0;
        level <= 3'h0;
      end else begin
        if (do_wr) wptr <= wptr + 2'h1;
        if (do_rd) rptr <= rptr + 2'h1;
        level <= level + {2'h0, do_wr} - {2'h0, do_rd};
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (ce && do_wr) mem[wptr] <= wr_data;
  end

endmodule : sfrxc_rx_fifo

`default_nettype wire

// ===== verilog/sfrxc_top.sv
/*
  FIFO configuration and receive FIFO control for a serial channel:
  enable and depth split, auto-stop of transmit/receive, receive clear and
  receive interrupt threshold. Assumes an APB master and a shift-register
  side that reports buffer occupancy as plain levels.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// [R1] Half-duplex receive auto-stop clears receive enable when byte count reached.
// [R2] Half-duplex transmit auto-stop clears transmit enable when all transmit stages empty.
// [R3] Full-duplex auto-stop clears both enables on either condition.
// [R4] FIFO enable bit: 0 disables, 1 enables.
// [R5] Depth split: 4 receive, 4 transmit, or 2 and 2 by duplex.
// [R6] Transmit FIFO always offers its full configured depth.
// [R7] Software avoids the FIFO in 9-bit asynchronous mode.
// [R8] Receive clear empties FIFO, zeroes level, resets pointers, reads 0.
// [R9] Receive interrupt on level equal or at least threshold per select.
// [R10] Software clears FIFOs after duplex select and enable, before use.
// [R11] Usage select picks max depth or threshold as auto-stop count.
// [R12] Single-cycle receive request when condition becomes true after a write.
// [R13] Unused bits read zero; control fields reset to zero.
module sfrxc_top #(
  parameter int WIDTH = 8
) (
  // APB
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Receive shift side
  input  wire logic             rx_byte_valid,
  input  wire logic [WIDTH-1:0] rx_byte,
  input  wire logic             rx_stage_full,
  input  wire logic             fifo_rd_ready,
  // Transmit side status
  input  wire logic             tx_all_empty,
  // Channel outputs
  output logic                  fifo_rd_valid,
  output logic      [WIDTH-1:0] fifo_rd_data,
  output logic                  rx_fifo_full,
  output logic                  rx_enable,
  output logic                  tx_enable,
  output logic      [2:0]       tx_fifo_depth,
  output logic                  rx_irq
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic       fifo_en;
  logic       auto_stop_on_count;
  logic       rx_fifo_usage_select;
  logic       rx_irq_condition_select;
  logic [1:0] rx_level_code;
  logic [1:0] duplex;
  logic       nine_bit;
  logic       irq_cond_q;
  logic       wrote_q;

  wire        wr_acc  = psel && penable && pwrite && ce;
  wire        sel_gen = (paddr == sfrxc_pkg::OFS_GENERAL);
  wire        sel_rxc = (paddr == sfrxc_pkg::OFS_RXCFG);
  wire        sel_sts = (paddr == sfrxc_pkg::OFS_RXSTAT);
  wire        sel_ch  = (paddr == sfrxc_pkg::OFS_CHANNEL);
  wire        mapped  = sel_gen || sel_rxc || sel_sts || sel_ch;
  wire        rx_clear = wr_acc && sel_rxc && pwdata[sfrxc_pkg::RXC_CLEAR]; // see [R8]

  // ----------------------------------------------------------------------
  // Depth split and thresholds
  // ----------------------------------------------------------------------
  wire half_rx = (duplex == sfrxc_pkg::SFRXC_DPX_HALF_RX);
  wire half_tx = (duplex == sfrxc_pkg::SFRXC_DPX_HALF_TX);
  wire full_dx = (duplex == sfrxc_pkg::SFRXC_DPX_FULL);
  wire [2:0] rx_depth = !fifo_en ? 3'h0 :
                        half_rx ? sfrxc_pkg::DEPTH_HALF :
                        full_dx ? sfrxc_pkg::DEPTH_FULL : 3'h0; // see [R4] see [R5]
  // Transmit depth ignores the usage select
  wire [2:0] next_tx_depth = !fifo_en ? 3'h0 :
                             half_tx ? sfrxc_pkg::DEPTH_HALF :
                             full_dx ? sfrxc_pkg::DEPTH_FULL : 3'h0; // see [R5] see [R6]
  wire [2:0] threshold = (rx_level_code == 2'h0) ? rx_depth :
                         (rx_level_code == 2'h1) ? sfrxc_pkg::LVL_ONE :
                         (rx_level_code == 2'h2) ? sfrxc_pkg::LVL_TWO :
                         full_dx ? sfrxc_pkg::LVL_ONE : sfrxc_pkg::LVL_THREE; // see [R9]
  wire [2:0] stop_count = rx_fifo_usage_select ? threshold : rx_depth; // see [R11]

  logic [2:0] level;
  logic       fifo_wr_ready;
  // The one shift stage before the FIFO, when full, counts as one more valid byte
  wire  [2:0] rx_held = level + {2'h0, rx_stage_full};
  wire        rx_full_cond = rx_held >= stop_count && stop_count != 3'h0;
  wire        irq_cond = fifo_en && threshold != 3'h0 &&
                         (rx_irq_condition_select ? (level >= threshold)
                                                  : (level == threshold)); // see [R9]
  wire        stop_rx = auto_stop_on_count && fifo_en &&
                        ((half_rx && rx_full_cond) ||
                         (full_dx && (rx_full_cond || tx_all_empty))); // see [R1] see [R3]
  wire        stop_tx = auto_stop_on_count && fifo_en &&
                        ((half_tx && tx_all_empty) ||
                         (full_dx && (rx_full_cond || tx_all_empty))); // see [R2] see [R3]
  wire        fifo_push = rx_byte_valid && rx_enable;

  sfrxc_rx_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (int'(sfrxc_pkg::DEPTH_HALF))
  ) u_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .clear    (rx_clear),
    .limit    (rx_depth),
    .wr_valid (fifo_push),
    .wr_data  (rx_byte),
    .wr_ready (fifo_wr_ready),
    .rd_ready (fifo_rd_ready),
    .rd_valid (fifo_rd_valid),
    .rd_data  (fifo_rd_data),
    .level    (level)
  );

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  wire [31:0] rd_gen = {27'h0, rx_fifo_usage_select, 2'h0, auto_stop_on_count, fifo_en};
  wire [31:0] rd_rxc = {24'h0, 1'b0, rx_irq_condition_select, 4'h0, rx_level_code}; // see [R8]
  wire [31:0] rd_sts = {29'h0, level};
  wire [31:0] rd_ch  = {27'h0, nine_bit, tx_enable, rx_enable, duplex};
  wire [31:0] next_prdata = sel_gen ? rd_gen : sel_rxc ? rd_rxc :
                            sel_sts ? rd_sts : sel_ch ? rd_ch : 32'h0; // see [R13]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_en                 <= 1'b0;
      auto_stop_on_count      <= 1'b0;
      rx_fifo_usage_select    <= 1'b0;
      rx_irq_condition_select <= 1'b0;
      rx_level_code           <= 2'h0;
      duplex                  <= 2'h0;
      nine_bit                <= 1'b0;
    end else if (wr_acc) begin
      if (sel_gen) begin
        fifo_en              <= pwdata[sfrxc_pkg::GEN_FIFO_EN]; // see [R4]
        auto_stop_on_count   <= pwdata[sfrxc_pkg::GEN_AUTO_STOP];
        rx_fifo_usage_select <= pwdata[sfrxc_pkg::GEN_USAGE];
      end else if (sel_rxc) begin
        rx_irq_condition_select <= pwdata[sfrxc_pkg::RXC_COND];
        rx_level_code <= pwdata[sfrxc_pkg::RXC_LEVEL_LO +: 2];
      end else if (sel_ch) begin
        duplex   <= pwdata[sfrxc_pkg::CH_DUPLEX_LO +: 2];
        nine_bit <= pwdata[sfrxc_pkg::CH_NINE_BIT]; // Nine-bit FIFO use is software's problem
      end
    end
  end

  // Enables: auto-stop wins over a software set in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
    end else if (ce) begin
      if (stop_rx) rx_enable <= 1'b0; // see [R1] see [R3]
      else if (wr_acc && sel_ch) rx_enable <= pwdata[sfrxc_pkg::CH_RX_EN];
      if (stop_tx) tx_enable <= 1'b0; // see [R2] see [R3]
      else if (wr_acc && sel_ch) tx_enable <= pwdata[sfrxc_pkg::CH_TX_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata        <= sfrxc_pkg::RESET_VALUE;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      irq_cond_q    <= 1'b0;
      wrote_q       <= 1'b0;
      rx_irq        <= 1'b0;
      rx_fifo_full  <= 1'b0;
      tx_fifo_depth <= 3'h0;
    end else if (ce) begin
      pready        <= psel && !penable;
      pslverr       <= psel && !penable && !mapped;
      prdata        <= next_prdata;
      wrote_q       <= fifo_push && fifo_wr_ready;
      irq_cond_q    <= irq_cond;
      rx_irq        <= irq_cond && !irq_cond_q && wrote_q; // see [R12]
      rx_fifo_full  <= !fifo_wr_ready;
      tx_fifo_depth <= next_tx_depth; // see [R6]
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_clear_empties;
    @(posedge pclk) disable iff (!presetn) (rx_clear && ce) |=> (level == 3'h0);
  endproperty
  a_clear_empties: assert property (p_clear_empties) else $error("clear left level"); // see [R8]

  property p_irq_pulse;
    @(posedge pclk) disable iff (!presetn) rx_irq |=> !rx_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not one cycle"); // see [R12]

  property p_rx_stop;
    @(posedge pclk) disable iff (!presetn) (ce && stop_rx) |=> !rx_enable;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("rx not stopped"); // see [R1]

  property p_tx_stop;
    @(posedge pclk) disable iff (!presetn) (ce && stop_tx) |=> !tx_enable;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("tx not stopped"); // see [R2]

  property p_full_both;
    @(posedge pclk) disable iff (!presetn)
      (ce && auto_stop_on_count && fifo_en && full_dx && tx_all_empty) |=> (!rx_enable && !tx_enable);
  endproperty
  a_full_both: assert property (p_full_both) else $error("full duplex stop"); // see [R3]

  property p_depth_limit;
    @(posedge pclk) disable iff (!presetn) level <= sfrxc_pkg::DEPTH_HALF;
  endproperty
  a_depth_limit: assert property (p_depth_limit) else $error("level over depth"); // see [R5]

  property p_disabled_no_store;
    @(posedge pclk) disable iff (!presetn) (!fifo_en && level == 3'h0) |=> (level == 3'h0);
  endproperty
  a_disabled_no_store: assert property (p_disabled_no_store) else $error("store while off"); // see [R4]

  property p_tx_depth;
    @(posedge pclk) disable iff (!presetn) (ce && fifo_en && half_tx) |=> (tx_fifo_depth == sfrxc_pkg::DEPTH_HALF);
  endproperty
  a_tx_depth: assert property (p_tx_depth) else $error("tx depth wrong"); // see [R6]

endmodule : sfrxc_top

`default_nettype wire

// ===== dv/sfrxc_shift_model.sv
/*
  Far-side model: receive shift stage, FIFO reader and transmit status.
  Assumes the bench calls its tasks from the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module sfrxc_shift_model (
  // Clock
  input  wire logic       pclk,
  // Channel side
  output logic            rx_byte_valid,
  output logic      [7:0] rx_byte,
  output logic            rx_stage_full,
  output logic            fifo_rd_ready,
  output logic            tx_all_empty
);
  initial begin
    rx_byte_valid = 1'b0;
    rx_byte       = 8'h00;
    rx_stage_full = 1'b0;
    fifo_rd_ready = 1'b0;
    tx_all_empty  = 1'b0;
  end

  // Bytes go back to back; idle data is inverted so a stale byte never matches
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_byte_valid <= 1'b1;
      rx_byte       <= 8'hA0 + 8'(i);
    end
    @(posedge pclk);
    rx_byte_valid <= 1'b0;
    rx_byte       <= ~rx_byte;
  endtask : push

  task automatic set_tx_empty(input logic e);
    @(posedge pclk);
    tx_all_empty <= e;
  endtask : set_tx_empty

  // Shift stage holding one byte that has not reached the FIFO yet
  task automatic set_stage(input logic e);
    @(posedge pclk);
    rx_stage_full <= e;
  endtask : set_stage

  // One pop: ready stands for exactly one clock
  task automatic pop();
    @(posedge pclk);
    fifo_rd_ready <= 1'b1;
    @(posedge pclk);
    fifo_rd_ready <= 1'b0;
  endtask : pop
endmodule : sfrxc_shift_model

`default_nettype wire

// ===== dv/serial_fifo_rx_config_tb.sv
/*
  Bench for sfrxc_top: register access, depth split, receive clear,
  receive interrupt, clock enable and auto-stop. Assumes an APB slave
  that ends each access by raising pready.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_fifo_rx_config_tb;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ce      = 1'b1;
  logic        fifo_rd_valid;
  logic [7:0]  fifo_rd_data;
  logic        rx_fifo_full;
  logic        rx_byte_valid;
  logic [7:0]  rx_byte;
  logic        rx_stage_full;
  logic        fifo_rd_ready;
  logic        tx_all_empty;
  logic        rx_enable;
  logic        tx_enable;
  logic        rx_irq;
  logic [2:0]  tx_fifo_depth;
  logic [31:0] rd;
  int          miscompares = 0;
  int          check_count = 0;
  int          irq_cnt     = 0;
  int          base;

  always #5 pclk = ~pclk;
  always @(posedge pclk) if (rx_irq === 1'b1) irq_cnt <= irq_cnt + 1;

  sfrxc_shift_model fe (.pclk(pclk), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_stage_full(rx_stage_full), .fifo_rd_ready(fifo_rd_ready),
    .tx_all_empty(tx_all_empty));

  sfrxc_top #(.WIDTH(8)) uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_stage_full(rx_stage_full), .fifo_rd_ready(fifo_rd_ready),
    .tx_all_empty(tx_all_empty), .fifo_rd_valid(fifo_rd_valid), .fifo_rd_data(fifo_rd_data),
    .rx_fifo_full(rx_fifo_full), .rx_enable(rx_enable), .tx_enable(tx_enable),
    .tx_fifo_depth(tx_fifo_depth), .rx_irq(rx_irq));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // ----------------------------------------------------------------------
  // APB master; request held until the edge that samples pready high
  // ----------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    rd      = (pslverr === 1'b1) ? 32'hEEEE_EEEE : prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      finish_test();
    end
  endtask : apb

  task automatic t_regs();
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'hEEEE_EEEE);
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0000_0043);
  endtask : t_regs

  task automatic t_depth();
    logic [2:0] exp [4] = '{3'h0, 3'h4, 3'h0, 3'h2};
    // Usage select set: transmit depth must not follow it
    apb(1'b1, 8'h00, 32'h11);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h11);
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, 8'h0C, 32'(d));
      repeat (2) @(posedge pclk);
      check({29'h0, tx_fifo_depth}, {29'h0, exp[d]});
    end
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    check({29'h0, tx_fifo_depth}, 32'h0);
  endtask : t_depth

  // Software clears only after duplex select and enable
  // Nine-bit flag stays clear whenever the FIFO is in use
  task automatic setup_rx(input logic [31:0] gen, input logic [31:0] cfg);
    apb(1'b1, 8'h00, gen);
    apb(1'b1, 8'h0C, 32'h6);
    apb(1'b1, 8'h04, 32'h80);
    apb(1'b1, 8'h04, cfg);
  endtask : setup_rx

  task automatic t_irq_clear();
    setup_rx(32'h1, 32'h2);
    base = irq_cnt;
    fe.push(1);
    repeat (4) @(posedge pclk);
    check(32'(irq_cnt - base), 32'h0);
    fe.push(1);
    repeat (4) @(posedge pclk);
    check(32'(irq_cnt - base), 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, 8'h04, 32'h82);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    // At-least mode, threshold one: three writes give one request
    apb(1'b1, 8'h04, 32'h41);
    base = irq_cnt;
    fe.push(3);
    repeat (4) @(posedge pclk);
    check(32'(irq_cnt - base), 32'h1);
    fe.pop();
    @(posedge pclk);
    check({23'h0, fifo_rd_valid, fifo_rd_data}, 32'h0000_01A1);
    // Clock enable low: a pushed byte must not land
    apb(1'b1, 8'h04, 32'h80);
    @(posedge pclk);
    ce <= 1'b0;
    fe.push(1);
    @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
  endtask : t_irq_clear

  // Last valid byte comes either as a FIFO write or as a full shift stage
  task automatic stop_rx(input logic [31:0] gen, input logic [31:0] cfg, input int n,
                         input logic stage);
    setup_rx(gen, cfg);
    fe.push(n - 1);
    repeat (4) @(posedge pclk);
    check({31'h0, rx_enable}, 32'h1);
    if (stage) fe.set_stage(1'b1);
    else fe.push(1);
    repeat (4) @(posedge pclk);
    check({31'h0, rx_enable}, 32'h0);
    fe.set_stage(1'b0);
  endtask : stop_rx

  task automatic t_stop_tx();
    apb(1'b1, 8'h04, 32'h80);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h0C, 32'h9);
    @(posedge pclk);
    check({31'h0, tx_enable}, 32'h1);
    fe.set_tx_empty(1'b1);
    repeat (3) @(posedge pclk);
    check({31'h0, tx_enable}, 32'h0);
    fe.set_tx_empty(1'b0);
    apb(1'b1, 8'h0C, 32'hF);
    @(posedge pclk);
    check({30'h0, rx_enable, tx_enable}, 32'h3);
    fe.set_tx_empty(1'b1);
    repeat (3) @(posedge pclk);
    check({30'h0, rx_enable, tx_enable}, 32'h0);
    // Receive side reaching its two-byte depth stops both as well
    fe.set_tx_empty(1'b0);
    apb(1'b1, 8'h0C, 32'hF);
    fe.push(2);
    repeat (3) @(posedge pclk);
    check({30'h0, rx_enable, tx_enable}, 32'h0);
    check({31'h0, rx_fifo_full}, 32'h1);
    check({24'h0, fifo_rd_data}, 32'hA0);
    fe.pop();
    @(posedge pclk);
    check({24'h0, fifo_rd_data}, 32'hA1);
  endtask : t_stop_tx

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_depth();
    t_irq_clear();
    stop_rx(32'h13, 32'h3, 3, 1'b0);
    stop_rx(32'h03, 32'h0, 4, 1'b1);
    t_stop_tx();
    finish_test();
  end
endmodule : serial_fifo_rx_config_tb

`default_nettype wire
